// ===== src/slg_top.sv
// Sleep gating register bank and gated control outputs
`timescale 1ns/1ps
`default_nettype none
`include "slg_map.svh"
module slg_top (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire slg_pkg::slg_reg_req_t reg_req,
  output var  logic [7:0]            rd_data,
  input  wire logic                  sleep_mode,
  input  wire slg_pkg::slg_func_t    normal_ctrl,
  input  wire logic [4:0]            ldo_normal_code,
  output var  slg_pkg::slg_func_t    func_ctrl,
  output var  slg_pkg::slg_ldo_set_t ldo_set,
  output var  logic                  sleep_active
);
  import slg_pkg::*;

  logic [7:0]  core_q;
  logic [7:0]  sense_q;
  logic [7:0]  io_q;
  logic [4:0]  ldo_sleep_code_q;
  logic [7:0]  rd_data_q;
  logic        sleep_q;
  slg_phase_t  phase_q;
  slg_phase_t  phase_d;
  slg_func_t   held_q;
  slg_func_t   held_src;
  slg_func_t   keep;
  slg_func_t   off_val;
  slg_func_t   gated;
  slg_func_t   func_d;
  slg_func_t   func_q;
  logic [4:0]  ldo_code_d;
  slg_ldo_set_t ldo_set_q;
  logic        entering;

  // Clamp a code and convert it to millivolts
  function automatic logic [4:0] clamp_code(input logic [4:0] c);
    clamp_code = (c > `SLG_LDO_CLAMP_CODE) ? `SLG_LDO_CLAMP_CODE : c;
  endfunction

  function automatic logic [11:0] code_to_mv(input logic [4:0] c);
    logic [11:0] steps;
    steps = {7'h00, clamp_code(c)};
    code_to_mv = 12'(`SLG_LDO_BASE_MV + steps * `SLG_LDO_STEP_MV);
  endfunction

  // Register write path; reserved bits are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_q <= `SLG_RST_CORE;
    end else if (reg_req.wr_en && reg_req.addr == `SLG_OFS_CORE) begin
      core_q <= reg_req.wr_data & `SLG_MASK_CORE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sense_q <= `SLG_RST_SENSE;
    end else if (reg_req.wr_en && reg_req.addr == `SLG_OFS_SENSE) begin
      sense_q <= reg_req.wr_data & `SLG_MASK_SENSE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      io_q <= `SLG_RST_IO;
    end else if (reg_req.wr_en && reg_req.addr == `SLG_OFS_IO) begin
      io_q <= reg_req.wr_data & `SLG_MASK_IO;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ldo_sleep_code_q <= `SLG_RST_LDO_SLEEP;
    end else if (reg_req.wr_en && reg_req.addr == `SLG_OFS_LDO_SLEEP) begin
      ldo_sleep_code_q <= reg_req.wr_data[4:0];
    end
  end

  // Read path; unmapped offsets read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else if (reg_req.rd_en) begin
      unique case (reg_req.addr)
        `SLG_OFS_CORE:      rd_data_q <= core_q;
        `SLG_OFS_SENSE:     rd_data_q <= sense_q;
        `SLG_OFS_IO:        rd_data_q <= io_q;
        `SLG_OFS_LDO_SLEEP: rd_data_q <= {3'h0, ldo_sleep_code_q};
        default:            rd_data_q <= 8'h00;
      endcase
    end
  end

  // Sleep phase tracking
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      SLG_AWAKE:    if (sleep_mode) phase_d = SLG_ENTERING;
      SLG_ENTERING: phase_d = sleep_mode ? SLG_ASLEEP : SLG_AWAKE;
      SLG_ASLEEP:   if (!sleep_mode) phase_d = SLG_AWAKE;
      default:      phase_d = SLG_AWAKE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_q <= SLG_AWAKE;
    end else begin
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_mode;
    end
  end

  assign entering = sleep_mode && !sleep_q;

  // Snapshot of the running state at sleep entry
  // hold present state
  assign held_src = entering ? normal_ctrl : held_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      held_q <= '0;
    end else if (entering) begin
      held_q <= normal_ctrl;
    end
  end

  // Keep bits mapped onto functions
  always_comb begin
    keep = '0;
    keep.xtal_en                  = core_q[`SLG_BIT_XTAL];
    keep.buck_en                  = core_q[`SLG_BIT_BUCK];
    keep.buck_forced_pwm          = core_q[`SLG_BIT_BUCK];
    keep.ldo_en                   = core_q[`SLG_BIT_LDO];
    keep.gate_supply_high_current = core_q[`SLG_BIT_GATE_SUPPLY];
    keep.boost_en                 = core_q[`SLG_BIT_BOOST];
    keep.pa_driver_en             = core_q[`SLG_BIT_PA_DRIVER];
    keep.imp_driver_en            = core_q[`SLG_BIT_IMP_DRIVER];
    keep.imp_detector_en          = core_q[`SLG_BIT_IMP_DETECTOR];
    keep.relay_en                 = sense_q[`SLG_BIT_RELAY];
    keep.tx_peak_en               = sense_q[`SLG_BIT_TX_PEAK];
    keep.rf_peak_en               = sense_q[`SLG_BIT_RF_PEAK];
    keep.pa_peak_en               = sense_q[`SLG_BIT_PA_PEAK];
    keep.ac_meas_en               = sense_q[`SLG_BIT_AC_MEAS];
    keep.therm_pullup_en          = sense_q[`SLG_BIT_THERM_PULLUP];
    keep.adc_en                   = sense_q[`SLG_BIT_ADC];
    keep.led_one_en               = io_q[`SLG_BIT_LED_ONE];
    keep.led_two_en               = io_q[`SLG_BIT_LED_TWO];
    keep.pin_one_en               = io_q[`SLG_BIT_PIN_ONE];
    keep.pin_two_en               = io_q[`SLG_BIT_PIN_TWO];
  end

  // Cleared keep bit forces off, or low current for the gate supply
  assign off_val = '0;

  slg_gate #(
    .W ($bits(slg_func_t))
  ) u_gate (
    .sleep   (sleep_mode),
    .keep    (keep),
    .normal  (normal_ctrl),
    .held    (held_src),
    .off_val (off_val),
    .gated   (gated)
  );

  // Buck and LDO run in fixed sleep settings rather than held state
  always_comb begin
    func_d = gated;
    if (sleep_mode) begin
      func_d.buck_en         = core_q[`SLG_BIT_BUCK];
      func_d.buck_forced_pwm = 1'b0;
      func_d.ldo_en          = core_q[`SLG_BIT_LDO];
    end
  end

  assign ldo_code_d = sleep_mode ? ldo_sleep_code_q : ldo_normal_code;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      func_q <= '0;
    end else begin
      func_q <= func_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ldo_set_q <= '0;
    end else begin
      ldo_set_q.code <= clamp_code(ldo_code_d);
      ldo_set_q.mv   <= code_to_mv(ldo_code_d);
    end
  end

  assign rd_data      = rd_data_q;
  assign func_ctrl    = func_q;
  assign ldo_set      = ldo_set_q;
  assign sleep_active = (phase_q != SLG_AWAKE);

endmodule
`default_nettype wire

// ===== src/slg_map.svh
// Register offsets, field positions, reset values and LDO scaling for the sleep gating bank
// Contract
// - Oscillator off in sleep unless keep bit set
// - Buck off in sleep, else auto PFM/PWM
// - LDO off in sleep, else sleep code
// - Other keep bits hold present operating state
// - Impedance drivers and detector gated by bits 6,7
// - Relay driver off in sleep when cleared
// - Three peak detectors gated by bits 1-3
// - Pull-up, AC measurement, ADC gated in sleep
// - LED drivers two and one gated in sleep
// - GPIO two and one gated in sleep
// - Sleep LDO code 1.2V, 100mV steps, clamp 18h
`ifndef SLG_MAP_SVH
`define SLG_MAP_SVH

`define SLG_OFS_CORE          8'h13
`define SLG_OFS_SENSE         8'h14
`define SLG_OFS_IO            8'h15
`define SLG_OFS_LDO_SLEEP     8'h12

`define SLG_RST_CORE          8'h07
`define SLG_RST_SENSE         8'h00
`define SLG_RST_IO            8'h00
`define SLG_RST_LDO_SLEEP     5'h15

`define SLG_MASK_CORE         8'hff
`define SLG_MASK_SENSE        8'h7f
`define SLG_MASK_IO           8'h0f
`define SLG_MASK_LDO_SLEEP    8'h1f

`define SLG_BIT_XTAL          0
`define SLG_BIT_BUCK          1
`define SLG_BIT_LDO           2
`define SLG_BIT_GATE_SUPPLY   3
`define SLG_BIT_BOOST         4
`define SLG_BIT_PA_DRIVER     5
`define SLG_BIT_IMP_DRIVER    6
`define SLG_BIT_IMP_DETECTOR  7

`define SLG_BIT_RELAY         0
`define SLG_BIT_TX_PEAK       1
`define SLG_BIT_RF_PEAK       2
`define SLG_BIT_PA_PEAK       3
`define SLG_BIT_AC_MEAS       4
`define SLG_BIT_THERM_PULLUP  5
`define SLG_BIT_ADC           6

`define SLG_BIT_LED_TWO       0
`define SLG_BIT_LED_ONE       1
`define SLG_BIT_PIN_TWO       2
`define SLG_BIT_PIN_ONE       3

`define SLG_LDO_BASE_MV       12'h4b0
`define SLG_LDO_STEP_MV       12'h064
`define SLG_LDO_CLAMP_CODE    5'h18

`endif

// ===== src/slg_pkg.sv
// Types shared by the sleep gating bank
package slg_pkg;

  // One control level per gated function; all high means running
  typedef struct packed {
    logic xtal_en;
    logic buck_en;
    logic buck_forced_pwm;
    logic ldo_en;
    logic gate_supply_high_current;
    logic boost_en;
    logic pa_driver_en;
    logic imp_driver_en;
    logic imp_detector_en;
    logic relay_en;
    logic tx_peak_en;
    logic rf_peak_en;
    logic pa_peak_en;
    logic ac_meas_en;
    logic therm_pullup_en;
    logic adc_en;
    logic led_one_en;
    logic led_two_en;
    logic pin_one_en;
    logic pin_two_en;
  } slg_func_t;

  // Register access port from the serial control engine
  typedef struct packed {
    logic [7:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wr_data;
  } slg_reg_req_t;

  // LDO setting: sleep code in sleep mode, normal code when awake
  typedef struct packed {
    logic [4:0]  code;
    logic [11:0] mv;
  } slg_ldo_set_t;

  typedef enum logic [1:0] {
    SLG_AWAKE    = 2'b00,
    SLG_ENTERING = 2'b01,
    SLG_ASLEEP   = 2'b10
  } slg_phase_t;

endpackage

// ===== src/slg_gate.sv
// Per-bit sleep gate: normal level when awake, held or forced level when asleep
`timescale 1ns/1ps
`default_nettype none
module slg_gate #(
  parameter int W = 1
) (
  input  wire logic         sleep,
  input  wire logic [W-1:0] keep,
  input  wire logic [W-1:0] normal,
  input  wire logic [W-1:0] held,
  input  wire logic [W-1:0] off_val,
  output var  logic [W-1:0] gated
);
  always_comb begin
    gated = normal;
    if (sleep) begin
      gated = (keep & held) | (~keep & off_val);
    end
  end
endmodule
`default_nettype wire

// ===== verif/slg_top_monitor.sv
// Port-level assertions for the sleep gating bank
`timescale 1ns/1ps
`default_nettype none
module slg_monitor (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire slg_pkg::slg_reg_req_t reg_req,
  input wire logic [7:0]            rd_data,
  input wire logic                  sleep_mode,
  input wire slg_pkg::slg_func_t    normal_ctrl,
  input wire logic [4:0]            ldo_normal_code,
  input wire slg_pkg::slg_func_t    func_ctrl,
  input wire slg_pkg::slg_ldo_set_t ldo_set,
  input wire logic                  sleep_active
);
  import slg_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sense_resv_a: assert property (reg_req.rd_en && reg_req.addr == 8'h14
    |=> !rd_data[7]) else $error("sense reserved bit read high");
  io_resv_a: assert property (reg_req.rd_en && reg_req.addr == 8'h15
    |=> rd_data[7:4] == 4'h0) else $error("io reserved bits read high");
  code_resv_a: assert property (reg_req.rd_en && reg_req.addr == 8'h12
    |=> rd_data[7:5] == 3'h0) else $error("ldo code reserved bits read high");
  sleep_enter_a: assert property ($rose(sleep_mode) |-> ##[1:2] sleep_active)
    else $error("sleep not entered");
  sleep_exit_a: assert property ($fell(sleep_mode) |-> ##[1:2] !sleep_active)
    else $error("sleep not left");
  wake_follow_a: assert property (!sleep_mode |=> func_ctrl == $past(normal_ctrl))
    else $error("awake controls not followed");
  ldo_clamp_a: assert property (!sleep_mode |=> ldo_set.code ==
    ($past(ldo_normal_code) > 5'h18 ? 5'h18 : $past(ldo_normal_code)))
    else $error("ldo code not clamped");
  sleep_hold_a: assert property ((sleep_mode && !reg_req.wr_en)[*4]
    |=> $stable(func_ctrl)) else $error("controls moved in sleep");
  cover property ($rose(sleep_mode));
  cover property ($fell(sleep_mode));
  cover property (reg_req.wr_en && reg_req.addr == 8'h13);
  cover property (!sleep_mode ##1 sleep_mode ##1 !sleep_mode);
endmodule
bind slg_top slg_monitor mon_u (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
  .rd_data(rd_data), .sleep_mode(sleep_mode), .normal_ctrl(normal_ctrl),
  .ldo_normal_code(ldo_normal_code), .func_ctrl(func_ctrl), .ldo_set(ldo_set),
  .sleep_active(sleep_active));
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the sleep gating bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import slg_pkg::*;
  logic         core_clk;
  logic         rst;
  slg_reg_req_t reg_req;
  logic [7:0]   rd_data;
  logic         sleep_mode;
  slg_func_t    normal_ctrl;
  logic [4:0]   ldo_normal_code;
  slg_func_t    func_ctrl;
  slg_ldo_set_t ldo_set;
  logic         sleep_active;
  int           n_fail;
  int           compares;
  integer       seed;
  logic [7:0]   c;
  logic [7:0]   s;
  logic [7:0]   io;
  logic [4:0]   sc;
  slg_func_t    snap;

  slg_top dut_u (.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .rd_data(rd_data),
    .sleep_mode(sleep_mode), .normal_ctrl(normal_ctrl), .ldo_normal_code(ldo_normal_code),
    .func_ctrl(func_ctrl), .ldo_set(ldo_set), .sleep_active(sleep_active));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{a, 1'b1, 1'b0, d};
    @(posedge core_clk);
    reg_req.wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge core_clk);
    reg_req.rd_en <= 1'b0;
    #1 chk("rd_data", e, rd_data);
  endtask

  function automatic slg_ldo_set_t ldo_exp(input logic [4:0] x);
    logic [4:0] k;
    k = (x > 5'h18) ? 5'h18 : x;
    return '{k, 12'h4b0 + 12'h064 * k};
  endfunction

  // Kept functions hold the entry snapshot, buck and ldo follow their keep bits
  function automatic slg_func_t sleep_exp(input slg_func_t n);
    logic [19:0] m;
    m = {c[0], 3'b000, c[3], c[4], c[5], c[6], c[7], s[0], s[1], s[2], s[3], s[4],
         s[5], s[6], io[1], io[0], io[3], io[2]};
    return (n & m) | {1'b0, c[1], 1'b0, c[2], 16'h0000};
  endfunction

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    seed = 17643;
    n_fail = 0;
    compares = 0;
    rst = 1'b1;
    reg_req = '0;
    sleep_mode = 1'b0;
    normal_ctrl = '0;
    ldo_normal_code = 5'h00;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h13, 8'h07);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h00);
    rd(8'h12, 8'h15);
    for (int k = 0; k < 8; k++) begin
      {c, s, io, sc} = 29'($random(seed));
      if (k == 0) {c, s, io, sc} = '1;
      if (k == 1) {c, s, io, sc} = '0;
      wr(8'h13, c);
      wr(8'h14, s);
      wr(8'h15, io);
      wr(8'h12, {c[7:5], sc});
      wr(8'h16, c);
      rd(8'h13, c);
      rd(8'h14, s & 8'h7f);
      rd(8'h15, io & 8'h0f);
      rd(8'h12, {3'b000, sc});
      rd(8'h16, 8'h00);
      @(posedge core_clk);
      normal_ctrl <= 20'($random(seed));
      ldo_normal_code <= 5'($random(seed));
      repeat (2) @(posedge core_clk);
      #1 chk("func_ctrl", normal_ctrl, func_ctrl);
      chk("ldo_set", ldo_exp(ldo_normal_code), ldo_set);
      snap = normal_ctrl;
      @(posedge core_clk);
      sleep_mode <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk("sleep_active", 1, sleep_active);
      @(posedge core_clk);
      normal_ctrl <= 20'($random(seed));
      repeat (3) @(posedge core_clk);
      #1 chk("func_ctrl", sleep_exp(snap), func_ctrl);
      if (c[2]) chk("ldo_set", ldo_exp(sc), ldo_set);
      @(posedge core_clk);
      sleep_mode <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk("func_ctrl", normal_ctrl, func_ctrl);
      chk("sleep_active", 0, sleep_active);
      chk("ldo_set", ldo_exp(ldo_normal_code), ldo_set);
    end
    // One-cycle sleep pulse: entry phase falls straight back to awake
    @(posedge core_clk);
    sleep_mode <= 1'b1;
    @(posedge core_clk);
    sleep_mode <= 1'b0;
    #1 chk("sleep_active", 1, sleep_active);
    chk("func_ctrl", sleep_exp(normal_ctrl), func_ctrl);
    @(posedge core_clk);
    #1 chk("sleep_active", 0, sleep_active);
    chk("func_ctrl", normal_ctrl, func_ctrl);
    repeat (2) @(posedge core_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
